//--- hdl/wdcr_divider.sv
/*
 free-running source divider: fast prescaler tick and low-frequency tick.
 assumes: one core clock; never cleared by software, only by rstn.
*/
`timescale 1ns/1ns
`include "wdcr_regs.svh"
module wdcr_divider (
  input wire logic core_clk,
  input wire logic rstn,
  output logic hfTick,
  output logic lfTick
);
  import wdcr_pkg::*;

  logic [`WDCR_HF_PRE_BITS-1:0] preCount;
  logic [`WDCR_HF_PRE_BITS-1:0] next_preCount;
  logic [11:0] lfCount;
  logic [11:0] next_lfCount;
  logic next_hfTick;
  logic next_lfTick;

  always_comb begin
    next_preCount = preCount + 1'b1;
    next_hfTick = &preCount;
    next_lfTick = 1'b0;
    next_lfCount = lfCount + 12'h001;
    if (lfCount == (`WDCR_LF_DIV - 12'h001)) begin
      next_lfCount = 12'h000;
      next_lfTick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      preCount <= '0;
      lfCount <= 12'h000;
      hfTick <= 1'b0;
      lfTick <= 1'b0;
    end else begin
      preCount <= next_preCount;
      lfCount <= next_lfCount;
      hfTick <= next_hfTick;
      lfTick <= next_lfTick;
    end
  end
endmodule : wdcr_divider

//--- hdl/wdcr_top.sv
/*
 watchdog control block: write-only configuration and code registers,
 binary counter, overflow action, event status and mask, on Avalon-MM.
 assumes: mode inputs synchronous to core_clk; core_clk stands in for the
 fast oscillator; one bus access at a time.
*/
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "wdcr_regs.svh"
module wdcr_top #(
  parameter int HF_EXP = `WDCR_HF_EXP_LONGEST,
  parameter int LF_EXP = `WDCR_LF_EXP_LONGEST,
  parameter int RESET_PULSE_CYCLES = `WDCR_RESET_PULSE
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic lowSpeedMode,
  input wire logic stopMode,
  input wire logic idleMode,
  output logic wdResetOut,
  output logic wdOverflowIrq
);
  import wdcr_pkg::*;

  logic hfTick;
  logic lfTick;

  wdcr_divider u_divider (
    .core_clk(core_clk),
    .rstn(rstn),
    .hfTick(hfTick),
    .lfTick(lfTick)
  );

  // bus slave
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic accRead;
  logic accWrite;
  logic lane0;
  wdcr_byte_t wrByte;

  assign accRead = avs_read && !avs_waitrequest;
  assign accWrite = avs_write && !avs_waitrequest;
  assign lane0 = avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];

  // configuration and run state
  logic wdRunEnable;
  wdcr_tsel_t wdTimeoutSelect;
  logic wdActionSelect;
  logic running;
  logic next_wdRunEnable;
  wdcr_tsel_t next_wdTimeoutSelect;
  logic next_wdActionSelect;
  logic next_running;
  logic cfgWrite;
  logic codeWrite;
  logic clearCode;
  logic disableCode;

  // events, mask, interrupt
  logic [`WDCR_EV_BITS-1:0] evStatus;
  logic [`WDCR_EV_BITS-1:0] evMask;
  logic [`WDCR_EV_BITS-1:0] next_evStatus;
  logic [`WDCR_EV_BITS-1:0] next_evMask;
  logic [`WDCR_EV_BITS-1:0] evSet;
  logic next_wdOverflowIrq;

  // counter and output pulse
  logic [21:0] binCount;
  logic [21:0] next_binCount;
  logic [21:0] terminal;
  logic [4:0] expSel;
  logic srcTick;
  logic overflow;
  wdcr_out_state_t outState;
  wdcr_out_state_t next_outState;
  logic [20:0] pulseCount;
  logic [20:0] next_pulseCount;
  logic next_wdResetOut;

  assign cfgWrite = accWrite && lane0 && (avs_address == `WDCR_OFS_CONFIG);
  assign codeWrite = accWrite && lane0 && (avs_address == `WDCR_OFS_CODE);
  assign clearCode = codeWrite && (wrByte == `WDCR_CODE_CLEAR);
  // other codes decode to nothing
  assign disableCode = codeWrite && (wrByte == `WDCR_CODE_DISABLE);

  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          `WDCR_OFS_STATUS: next_readdata[`WDCR_EV_BITS-1:0] = evStatus;
          `WDCR_OFS_MASK: next_readdata[`WDCR_EV_BITS-1:0] = evMask;
          `WDCR_OFS_STATE: begin
            next_readdata[0] = running;
            next_readdata[1] = (outState == WDCR_OUT_PULSE);
          end
          // write-only and unmapped words read zero
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  always_comb begin
    next_wdRunEnable = wdRunEnable;
    next_wdTimeoutSelect = wdTimeoutSelect;
    next_wdActionSelect = wdActionSelect;
    next_running = running;
    if (cfgWrite) begin
      next_wdRunEnable = wrByte[`WDCR_BIT_RUN_ENABLE];
      next_wdTimeoutSelect = wrByte[`WDCR_BIT_TSEL_HI:`WDCR_BIT_TSEL_LO];
      // one-way: a one can never come back
      next_wdActionSelect = wdActionSelect & wrByte[`WDCR_BIT_ACTION];
      // enable bit low leaves the counter running
      if (wrByte[`WDCR_BIT_RUN_ENABLE]) begin
        next_running = 1'b1;
      end
    end
    // code before clearing the bit stays ignored
    if (disableCode && !wdRunEnable) begin
      next_running = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wdRunEnable <= `WDCR_RST_RUN_ENABLE;
      wdTimeoutSelect <= `WDCR_RST_TSEL;
      wdActionSelect <= `WDCR_RST_ACTION;
      running <= 1'b1;
    end else begin
      wdRunEnable <= next_wdRunEnable;
      wdTimeoutSelect <= next_wdTimeoutSelect;
      wdActionSelect <= next_wdActionSelect;
      running <= next_running;
    end
  end

  // binary counter; exponent drops two per select step
  always_comb begin
    if (lowSpeedMode) begin
      expSel = 5'(LF_EXP - 2 * int'(wdTimeoutSelect));
      srcTick = lfTick;
    end else begin
      expSel = 5'(HF_EXP - `WDCR_HF_PRE_BITS - 2 * int'(wdTimeoutSelect));
      srcTick = hfTick;
    end
    terminal = (22'h000001 << expSel) - 22'h000001;
  end

  // stop and idle freeze the count in place
  assign overflow = running && srcTick && !stopMode && !idleMode &&
                    !clearCode && (binCount == terminal);

  always_comb begin
    next_binCount = binCount;
    if (!running || (disableCode && !wdRunEnable)) begin
      next_binCount = 22'h000000;
    end else if (clearCode) begin
      // the prescaler keeps its phase, first period may be short
      next_binCount = 22'h000000;
    end else if (srcTick && !stopMode && !idleMode) begin
      if (binCount == terminal) begin
        next_binCount = 22'h000000;
      end else begin
        next_binCount = binCount + 22'h000001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      binCount <= 22'h000000;
    end else begin
      binCount <= next_binCount;
    end
  end

  // overflow routed by action bit
  always_comb begin
    evSet = '0;
    evSet[`WDCR_BIT_EV_IRQ] = overflow && !wdActionSelect;
    evSet[`WDCR_BIT_EV_RST] = overflow && wdActionSelect;
  end

  // reset pulse stretcher, a new overflow during a pulse is absorbed
  always_comb begin
    next_outState = outState;
    next_pulseCount = pulseCount;
    next_wdResetOut = 1'b0;
    unique case (outState)
      WDCR_OUT_IDLE: begin
        if (evSet[`WDCR_BIT_EV_RST]) begin
          next_outState = WDCR_OUT_PULSE;
          next_pulseCount = 21'h000000;
          next_wdResetOut = 1'b1;
        end
      end
      WDCR_OUT_PULSE: begin
        next_wdResetOut = 1'b1;
        next_pulseCount = pulseCount + 21'h000001;
        if (pulseCount == 21'(RESET_PULSE_CYCLES - 1)) begin
          next_outState = WDCR_OUT_IDLE;
          next_wdResetOut = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      outState <= WDCR_OUT_IDLE;
      pulseCount <= 21'h000000;
      wdResetOut <= 1'b0;
    end else begin
      outState <= next_outState;
      pulseCount <= next_pulseCount;
      wdResetOut <= next_wdResetOut;
    end
  end

  // sticky events; a set in the clearing cycle wins
  always_comb begin
    next_evStatus = evStatus;
    next_evMask = evMask;
    if (accWrite && lane0 && (avs_address == `WDCR_OFS_STATUS)) begin
      next_evStatus = evStatus & ~wrByte[`WDCR_EV_BITS-1:0];
    end
    if (accWrite && lane0 && (avs_address == `WDCR_OFS_MASK)) begin
      next_evMask = wrByte[`WDCR_EV_BITS-1:0];
    end
    next_evStatus = next_evStatus | evSet;
    next_wdOverflowIrq = |(next_evStatus & next_evMask);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      evStatus <= '0;
      evMask <= '0;
      wdOverflowIrq <= 1'b0;
    end else begin
      evStatus <= next_evStatus;
      evMask <= next_evMask;
      wdOverflowIrq <= next_wdOverflowIrq;
    end
  end
endmodule : wdcr_top

//--- pkg/wdcr_pkg.sv
/*
 types shared by the watchdog control block.
 assumes: nothing beyond the constants header.
*/
package wdcr_pkg;
  typedef logic [7:0] wdcr_byte_t;
  typedef logic [1:0] wdcr_tsel_t;
  typedef enum logic [0:0] {WDCR_OUT_IDLE, WDCR_OUT_PULSE} wdcr_out_state_t;
endpackage : wdcr_pkg

//--- pkg/wdcr_regs.svh
/*
 watchdog control block: register offsets, field positions, reset values,
 command codes and timing counts.
 assumes: included by bare name from the hdl files; definitions only.
*/
// Behaviour
// - clearing enable alone never stops; one enables
// - timeout field picks overflow period, fast/slow
// - action bit zero interrupts, one resets
// - action bit, once zero, stays zero
// - configuration register reads back as zero
// - configuration resets to enabled, longest, reset
// - code 4e clears binary counter
// - code b1 disables; other codes ignored
// - disable code needs enable already cleared
// - counter clear leaves source divider running
// - uncleared overflow fires reset or interrupt
// - enable bit sits at bit three
// - counter holds during stop and idle
// - correct disable clears binary counter
`ifndef WDCR_REGS_SVH
`define WDCR_REGS_SVH

`define WDCR_OFS_CONFIG 5'h00
`define WDCR_OFS_CODE 5'h04
`define WDCR_OFS_STATUS 5'h08
`define WDCR_OFS_MASK 5'h0c
`define WDCR_OFS_STATE 5'h10

`define WDCR_BIT_RUN_ENABLE 3
`define WDCR_BIT_TSEL_HI 2
`define WDCR_BIT_TSEL_LO 1
`define WDCR_BIT_ACTION 0

`define WDCR_RST_RUN_ENABLE 1'b1
`define WDCR_RST_TSEL 2'h0
`define WDCR_RST_ACTION 1'b1

`define WDCR_CODE_CLEAR 8'h4e
`define WDCR_CODE_DISABLE 8'hb1

`define WDCR_BIT_EV_IRQ 0
`define WDCR_BIT_EV_RST 1
`define WDCR_EV_BITS 2

// overflow exponents of the longest setting, in source clock cycles
`define WDCR_HF_EXP_LONGEST 25
`define WDCR_LF_EXP_LONGEST 17
// free prescaler ahead of the binary counter on the fast clock
`define WDCR_HF_PRE_BITS 4
// core cycles per low-frequency tick (100 MHz / 32.768 kHz)
`define WDCR_LF_DIV 12'hbec
// reset output time in fast clock cycles, 2^20
`define WDCR_RESET_PULSE 1048576

`endif

//--- tb/watchdog_control_registers_test.sv
/* self-checking bench for the watchdog control block.
 assumes: short counts HF_EXP 10, LF_EXP 8, pulse 8; design register map. */
`timescale 1ns/1ns
module watchdog_control_registers_test;
  logic core_clk = 0, rstn = 0, rd = 0, wr = 0, lowSpeed = 0;
  logic stop = 0, idle = 0, waitReq, rstOut, irq;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [31:0] rdata, q;
  int n_errors = 0, samples_checked = 0, k;
  wdcr_top #(.HF_EXP(10), .LF_EXP(8), .RESET_PULSE_CYCLES(8)) DUT (
    .core_clk(core_clk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata({24'h0, wdata}), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .lowSpeedMode(lowSpeed), .stopMode(stop), .idleMode(idle),
    .wdResetOut(rstOut), .wdOverflowIrq(irq));
  initial forever #5 core_clk = ~core_clk;
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low
  // one plain read or write, never read-modify-write
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitReq !== 1'b0 && n < 9);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 9) begin
      n_errors++;
      stop_test();
    end
    @(posedge core_clk);
  endtask : bus
  task await(input bit s, input int lim);
    k = 0;
    while ((s ? irq : rstOut) !== 1'b1 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= lim) begin
      n_errors++;
      stop_test();
    end
  endtask : await
  task t_reset;
    bus(0, 5'h00, 8'h0); chk(q, 0);
    bus(0, 5'h04, 8'h0); chk(q, 0);
    bus(0, 5'h10, 8'h0); chk(q, 1);
    bus(0, 5'h14, 8'h0); chk(q, 0);
    await(0, 1100); chk(k > 900, 1);
    bus(0, 5'h08, 8'h0); chk(q, 2);
    $display("reset test done");
  endtask : t_reset
  task t_order;
    bus(1, 5'h04, 8'hb1);
    bus(0, 5'h10, 8'h0); chk(q[0], 1);
    bus(1, 5'h00, 8'h07);
    bus(0, 5'h10, 8'h0); chk(q[0], 1);
    bus(1, 5'h04, 8'h55);
    bus(0, 5'h10, 8'h0); chk(q[0], 1);
    bus(1, 5'h04, 8'hb1);
    bus(0, 5'h10, 8'h0); chk(q[0], 0);
    repeat (12) @(posedge core_clk);
    bus(1, 5'h08, 8'h03);
    repeat (100) @(posedge core_clk);
    bus(0, 5'h08, 8'h0); chk(q, 0);
    bus(1, 5'h00, 8'h0f);
    await(0, 40); chk(rstOut, 1);
    bus(0, 5'h10, 8'h0); chk(q[1], 1);
    $display("disable order test done");
  endtask : t_order
  task t_irq;
    bus(1, 5'h0c, 8'h01);
    bus(1, 5'h00, 8'h0e);
    bus(1, 5'h00, 8'h0f);
    repeat (12) @(posedge core_clk);
    bus(1, 5'h08, 8'h03);
    await(1, 60); chk(rstOut, 0);
    bus(0, 5'h08, 8'h0); chk(q, 1);
    bus(1, 5'h0c, 8'h00);
    @(posedge core_clk); chk(irq, 0);
    bus(1, 5'h00, 8'h06);
    bus(1, 5'h04, 8'hb1);
    bus(1, 5'h08, 8'h03);
    bus(1, 5'h0c, 8'h01);
    @(posedge core_clk); chk(irq, 0);
    $display("interrupt test done");
  endtask : t_irq
  task t_clear;
    bus(1, 5'h00, 8'h08);
    repeat (4) begin
      repeat (600) @(posedge core_clk);
      bus(1, 5'h04, 8'h4e);
    end
    bus(0, 5'h08, 8'h0); chk(q, 0);
    // counter freshly cleared just before stop
    stop <= 1'b1;
    repeat (1500) @(posedge core_clk);
    stop <= 1'b0;
    idle <= 1'b1;
    repeat (1500) @(posedge core_clk);
    idle <= 1'b0;
    bus(0, 5'h08, 8'h0); chk(q, 0);
    await(1, 1100); chk(k > 900, 1);
    $display("clear and hold test done");
  endtask : t_clear
  task t_slow;
    lowSpeed <= 1'b1;
    bus(1, 5'h00, 8'h0e);
    bus(1, 5'h04, 8'h4e);
    bus(1, 5'h08, 8'h03);
    await(1, 16000); chk(k > 8000, 1);
    $display("slow clock test done");
  endtask : t_slow
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_order();
    t_irq();
    t_clear();
    t_slow();
    stop_test();
  end
endmodule : watchdog_control_registers_test

//--- tb/wdcr_properties.sv
/* port checker for the watchdog control block.
 assumes: bound into wdcr_top; one clock, rstn synchronous active low. */
`timescale 1ns/1ns
module wdcr_properties #(
  parameter int RESET_PULSE_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic stopMode,
  input wire logic idleMode,
  input wire logic wdResetOut
);
  int hiCnt;
  int next_hiCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // counts high samples so the pulse width is seen at its end
  always_comb next_hiCnt = wdResetOut ? hiCnt + 1 : 0;
  always_ff @(posedge core_clk) hiCnt <= rstn ? next_hiCnt : 0;
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no bus answer");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_wo_zero: assert property (
    avs_read && avs_waitrequest && (avs_address == 5'h00 ||
    avs_address == 5'h04) |=> avs_readdata == 32'h0)
    else $error("write-only register read nonzero");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
    avs_address > 5'h10 |=> avs_readdata == 32'h0)
    else $error("unmapped read nonzero");
  a_pulse_len: assert property (
    $fell(wdResetOut) |-> hiCnt == RESET_PULSE_CYCLES)
    else $error("reset pulse width wrong");
  a_pulse_max: assert property (
    wdResetOut |-> hiCnt < RESET_PULSE_CYCLES)
    else $error("reset pulse too long");
  a_hold_no_fire: assert property (
    $rose(wdResetOut) |-> !$past(stopMode) && !$past(idleMode))
    else $error("overflow while held");
  a_reset_quiet: assert property (
    $rose(rstn) |-> avs_waitrequest && !wdResetOut)
    else $error("outputs busy after reset");
endmodule : wdcr_properties

bind wdcr_top wdcr_properties #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES))
  u_props (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .stopMode(stopMode),
  .idleMode(idleMode), .wdResetOut(wdResetOut));
